// ==== src/pmic_link_host.sv ====
// Host end: Wishbone-controlled serial master for one register access
`timescale 1ns/1ps
module pmic_link_host (
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // Wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Serial link
  pmic_link_if.host        link
);
  import pmic_link_pkg::*;

  typedef enum logic [1:0] {K_START, K_BYTE, K_RBYTE, K_STOP} item_type;

  typedef struct packed {
    logic [1:0]  sda_s;
    logic        ack;
    logic [31:0] dat_o;
    logic        busy;
    logic        nack;
    logic        rd;
    logic [7:0]  regaddr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [2:0]  idx;
    logic [3:0]  bitn;
    logic [1:0]  q;
    logic [4:0]  tick;
    logic [7:0]  sh;
    logic        scl_oe;
    logic        sda_oe;
  } host_state_type;

  host_state_type cur;
  host_state_type nxt;

  localparam logic [4:0] TICK_LAST = 5'(QUARTER_CYCLES - 1);

  // write is 5 items, read 7 with a re-address
  function automatic item_type kind(input logic [2:0] i, input logic r);
    item_type k;
    k = K_BYTE;
    if (i == 3'h0 || (r && i == 3'h3)) k = K_START;
    else if ((!r && i == 3'h4) || i == 3'h6) k = K_STOP;
    else if (r && i == 3'h5) k = K_RBYTE;
    return k;
  endfunction : kind

  function automatic logic [7:0] byte_of(input logic [2:0] i,
                                         input host_state_type s);
    logic [7:0] b;
    b = {SLAVE_ADDR, 1'b0};
    if (i == 3'h2) b = s.regaddr;
    else if (i == 3'h3) b = s.wdata;
    else if (i == 3'h4) b = {SLAVE_ADDR, 1'b1};
    return b;
  endfunction : byte_of

  // Bus slave and bit sequencer
  always_comb begin
    logic sda;
    logic [2:0] nx;
    nxt = cur;
    nxt.sda_s = {cur.sda_s[0], link.sda};
    sda = cur.sda_s[1];
    nx = cur.idx + 3'h1;
    // One wait state, ack dropped after one cycle
    nxt.ack = wb_cyc_i && wb_stb_i && !cur.ack;
    if (nxt.ack) begin
      nxt.dat_o = 32'h0000_0000;
      if (!wb_we_i && wb_adr_i == HOST_STAT_ADDR) begin
        nxt.dat_o = {16'h0000, cur.rdata, 6'h00, cur.nack, cur.busy};
      end
      // Start only when idle and the command lane is enabled
      if (wb_we_i && wb_adr_i == HOST_CTRL_ADDR && !cur.busy &&
          wb_sel_i[2]) begin
        nxt.busy = 1'b1;
        nxt.nack = 1'b0;
        nxt.rd = wb_dat_i[HOST_READ_BIT];
        if (wb_sel_i[1]) nxt.regaddr = wb_dat_i[15:8];
        if (wb_sel_i[0]) nxt.wdata = wb_dat_i[7:0];
        nxt.idx = 3'h0;
        nxt.q = 2'h0;
        nxt.bitn = 4'h0;
        nxt.tick = 5'h00;
      end
    end
    if (cur.busy) begin
      nxt.tick = (cur.tick == TICK_LAST) ? 5'h00 : cur.tick + 5'h01;
      if (cur.tick == TICK_LAST) begin
        nxt.q = cur.q + 2'h1;
        case (kind(cur.idx, cur.rd))
          // start: data falls while clock high
          K_START: begin
            case (cur.q)
              2'h0: begin nxt.scl_oe = 1'b1; nxt.sda_oe = 1'b0; end
              2'h1: nxt.scl_oe = 1'b0;
              2'h2: nxt.sda_oe = 1'b1;
              default: begin
                nxt.scl_oe = 1'b1;
                nxt.idx = nx;
                nxt.sh = byte_of(nx, cur);
              end
            endcase
          end
          // stop: data rises while clock high
          K_STOP: begin
            case (cur.q)
              2'h0: begin nxt.scl_oe = 1'b1; nxt.sda_oe = 1'b1; end
              2'h1: nxt.scl_oe = 1'b0;
              2'h2: nxt.sda_oe = 1'b0;
              default: nxt.busy = 1'b0;
            endcase
          end
          default: begin
            case (cur.q)
              2'h0: begin
                nxt.scl_oe = 1'b1;
                nxt.sda_oe = (kind(cur.idx, cur.rd) == K_BYTE) &&
                             cur.bitn != 4'h8 && !cur.sh[7];
              end
              2'h1: nxt.scl_oe = 1'b0;
              2'h2: begin
                if (cur.bitn != 4'h8) begin
                  nxt.sh = {cur.sh[6:0], sda};
                end else if (kind(cur.idx, cur.rd) == K_BYTE && sda) begin
                  nxt.nack = 1'b1;
                end
              end
              default: begin
                nxt.scl_oe = 1'b1;
                nxt.bitn = cur.bitn + 4'h1;
                if (cur.bitn == 4'h8) begin
                  nxt.bitn = 4'h0;
                  nxt.sda_oe = 1'b0;
                  if (kind(cur.idx, cur.rd) == K_RBYTE) begin
                    nxt.rdata = cur.sh;
                  end
                  nxt.idx = nxt.nack ? (cur.rd ? 3'h6 : 3'h4) : nx;
                  nxt.sh = byte_of(nx, cur);
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
      cur.sda_s <= 2'b11;
    end else if (clk_en) begin
      cur <= nxt;
    end
  end

  assign wb_ack_o = cur.ack;
  assign wb_dat_o = cur.dat_o;
  assign link.host_scl_o  = 1'b0;
  assign link.host_scl_oe = cur.scl_oe;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = cur.sda_oe;
endmodule : pmic_link_host

// ==== src/pmic_link_if.sv ====
// Open-drain clock and data lines joining host and device
`timescale 1ns/1ps
interface pmic_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-up: any enabled driver wins
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) &
               (dev_sda_oe ? dev_sda_o : 1'b1);
  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
                input scl, sda);
  modport device (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface : pmic_link_if

// ==== src/pmic_link_pkg.sv ====
// Shared constants for the power-management serial register link
package pmic_link_pkg;
  // Serial link
  localparam logic [6:0] SLAVE_ADDR        = 7'h48;
  localparam int         CLK_PERIOD_NS     = 40;
  localparam int         LINK_MIN_PERIOD_NS = 2500;
  localparam int         QUARTER_CYCLES    =
    (LINK_MIN_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Device register map
  localparam logic [7:0] REG_VERSION  = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h01;
  localparam logic [7:0] REG_MASK     = 8'h02;
  localparam logic [7:0] REG_ENABLE   = 8'h03;
  localparam logic [7:0] READ_UNMAPPED = 8'hFF;
  localparam logic [7:0] MASK_RESET   = 8'hC0;
  localparam logic [7:0] MASK_WRITABLE = 8'hFE;
  localparam logic [7:0] ENABLE_RESET = 8'hFF;
  localparam logic [7:0] ENABLE_WRITABLE = 8'h3E;
  // Status bit positions
  localparam int BIT_POWER_FAIL  = 7;
  localparam int BIT_LOW_BATTERY = 6;
  localparam int BIT_BUCK3       = 3;
  // Host command registers on the Wishbone side
  localparam logic [7:0] HOST_CTRL_ADDR = 8'h00;
  localparam logic [7:0] HOST_STAT_ADDR = 8'h04;
  localparam int HOST_READ_BIT = 16;
endpackage : pmic_link_pkg

// ==== src/pmic_serial_regs.sv ====
// Device end: serial slave with status, mask and enable registers
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
module pmic_serial_regs #(
  parameter logic [7:0] VERSION_CODE = 8'h5A  // Arbitrary value
) (
  // Clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  // Serial link
  pmic_link_if.device     link,
  // Analog monitors and pins
  input  wire logic       supply_undervolt_lockout,
  input  wire logic       power_fail_sense,
  input  wire logic       low_battery_sense,
  input  wire logic [4:0] rail_below_target,
  input  wire logic       core_voltage_ramp,
  input  wire logic       buck1_enable_pin,
  input  wire logic       buck2_enable_pin,
  input  wire logic       buck3_enable_pin,
  input  wire logic       linear_reg_enable_pin,
  // Outputs
  output logic [4:0]      supply_on,
  output logic            device_on,
  output logic            int_n_o,
  output logic            int_n_oe
);
  import pmic_link_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_RX, S_ACK, S_TX, S_TXACK
  } slave_state_type;

  typedef struct packed {
    logic [14:0]     sync1;
    logic [14:0]     sync2;
    logic            scl_prev;
    logic            sda_prev;
    slave_state_type st;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic [1:0]      phase;
    logic            rw;
    logic            master_ack;
    logic [7:0]      ptr;
    logic            sda_oe;
    logic [7:0]      mask;
    logic [7:0]      enable;
    logic            released;
    logic [4:0]      supply_on;
    logic            device_on;
    logic            int_oe;
  } dev_state_type;

  dev_state_type cur;
  dev_state_type nxt;

  logic       scl;
  logic       sda;
  logic       lockout;
  logic [4:0] rail_low;
  logic [4:0] pins;
  logic [7:0] status;
  logic       active;

  // Second sync stage is the only reader of the first
  assign scl  = cur.sync2[14];
  assign sda  = cur.sync2[13];
  assign lockout = cur.sync2[12];
  assign rail_low = cur.sync2[8:4];
  // Shared linear pin drives both linear rails (bits 2 and 1)
  assign pins = {cur.sync2[3:1], cur.sync2[0], cur.sync2[0]};

  // Fault flags, live from monitors
  always_comb begin
    status = 8'h00;
    status[BIT_POWER_FAIL]  = cur.sync2[11];
    status[BIT_LOW_BATTERY] = cur.sync2[10];
    // rails below target, zero when disabled
    status[5:1] = rail_low & cur.supply_on;
    if (cur.sync2[9]) begin
      status[BIT_BUCK3] = 1'b0;
    end
  end

  assign active = |(status & ~cur.mask);

  // Register read mux
  function automatic logic [7:0] read_reg(input logic [7:0] a,
                                          input logic [7:0] st,
                                          input logic [7:0] m,
                                          input logic [7:0] e);
    logic [7:0] r;
    r = READ_UNMAPPED;
    case (a)
      REG_VERSION: r = VERSION_CODE;
      REG_STATUS:  r = st;
      REG_MASK:    r = m;
      REG_ENABLE:  r = e;
      default:     r = READ_UNMAPPED;
    endcase
    return r;
  endfunction : read_reg

  // Next-state logic for the whole slave
  always_comb begin
    logic start_seen;
    logic stop_seen;
    logic rise;
    logic fall;
    logic [7:0] rd;
    nxt = cur;
    start_seen = 1'b0;
    stop_seen = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    rd = 8'h00;
    nxt.sync1 = {link.scl, link.sda, supply_undervolt_lockout,
                 power_fail_sense, low_battery_sense, core_voltage_ramp,
                 rail_below_target, buck1_enable_pin, buck2_enable_pin,
                 buck3_enable_pin, linear_reg_enable_pin};
    nxt.sync2 = cur.sync1;
    nxt.scl_prev = scl;
    nxt.sda_prev = sda;
    // data edges while clock high are start or stop
    start_seen = scl && cur.scl_prev && cur.sda_prev && !sda;
    stop_seen  = scl && cur.scl_prev && !cur.sda_prev && sda;
    // 25 MHz sampling resolves 400 kHz edges
    rise = scl && !cur.scl_prev;
    fall = !scl && cur.scl_prev;
    if (start_seen) begin
      // Repeated start keeps the register pointer
      nxt.st = S_RX;
      nxt.cnt = 4'h0;
      nxt.phase = 2'h0;
      nxt.sda_oe = 1'b0;
    end else if (stop_seen) begin
      nxt.st = S_IDLE;
      nxt.sda_oe = 1'b0;
    end else begin
      case (cur.st)
        S_RX: begin
          if (rise) begin
            nxt.sh = {cur.sh[6:0], sda};
            nxt.cnt = cur.cnt + 4'h1;
          end else if (fall && cur.cnt == 4'h8) begin
            nxt.st = S_ACK;
            nxt.sda_oe = 1'b1;
            case (cur.phase)
              2'h0: begin
                nxt.rw = cur.sh[0];
                if (cur.sh[7:1] != SLAVE_ADDR) begin
                  nxt.st = S_IDLE;
                  nxt.sda_oe = 1'b0;
                end
              end
              2'h1: nxt.ptr = cur.sh;
              default: begin
                if (cur.ptr == REG_MASK) begin
                  nxt.mask = cur.sh & MASK_WRITABLE;
                end
                if (cur.ptr == REG_ENABLE) begin
                  nxt.enable = (cur.sh & ENABLE_WRITABLE) |
                               (ENABLE_RESET & ~ENABLE_WRITABLE);
                end
              end
            endcase
          end
        end
        S_ACK: begin
          if (fall) begin
            nxt.sda_oe = 1'b0;
            nxt.cnt = 4'h0;
            if (cur.rw) begin
              nxt.st = S_TX;
              rd = read_reg(cur.ptr, status, cur.mask, cur.enable);
              nxt.sh = rd;
              nxt.sda_oe = !rd[7];
              if (cur.ptr == REG_STATUS && active) begin
                nxt.released = 1'b1;
              end
            end else begin
              nxt.st = S_RX;
              nxt.phase = (cur.phase == 2'h2) ? 2'h2 : cur.phase + 2'h1;
            end
          end
        end
        S_TX: begin
          if (fall) begin
            if (cur.cnt == 4'h7) begin
              nxt.sda_oe = 1'b0;
              nxt.st = S_TXACK;
            end else begin
              nxt.cnt = cur.cnt + 4'h1;
              nxt.sh = {cur.sh[6:0], 1'b0};
              nxt.sda_oe = !cur.sh[6];
            end
          end
        end
        S_TXACK: begin
          if (rise) begin
            nxt.master_ack = !sda;
          end else if (fall) begin
            nxt.cnt = 4'h0;
            if (cur.master_ack) begin
              nxt.st = S_TX;
              rd = read_reg(cur.ptr, status, cur.mask, cur.enable);
              nxt.sh = rd;
              nxt.sda_oe = !rd[7];
            end else begin
              // leave data high for the stop
              nxt.st = S_IDLE;
            end
          end
        end
        default: nxt.sda_oe = 1'b0;
      endcase
    end
    // low pin forces its bit back to one
    nxt.enable = nxt.enable | {2'b00, ~pins, 1'b0};
    // Release lasts until the fault clears; the clear wins over a new read
    if (!active && !nxt.released) begin
      nxt.released = 1'b0;
    end else if (!active) begin
      nxt.released = 1'b0;
    end
    nxt.device_on = !lockout;
    if (lockout) begin
      nxt.mask = MASK_RESET;
      nxt.enable = ENABLE_RESET;
      nxt.st = S_IDLE;
      nxt.sda_oe = 1'b0;
      nxt.released = 1'b0;
    end
    // register bit and pin both needed
    nxt.supply_on = cur.enable[5:1] & pins & {5{!lockout}};
    // no rail on holds the interrupt low
    nxt.int_oe = (cur.supply_on == 5'h00) || (active && !cur.released);
  end

  // state held as long as the clock domain is powered
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
      cur.mask <= MASK_RESET;
      cur.enable <= ENABLE_RESET;
      cur.sync1 <= 15'h7FFF;
      cur.sync2 <= 15'h7FFF;
      cur.scl_prev <= 1'b1;
      cur.sda_prev <= 1'b1;
    end else if (clk_en) begin
      cur <= nxt;
    end
  end

  // Open-drain pins only ever pull low
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = cur.sda_oe;
  assign int_n_o   = 1'b0;
  assign int_n_oe  = cur.int_oe;
  assign supply_on = cur.supply_on;
  assign device_on = cur.device_on;
endmodule : pmic_serial_regs

// ==== tb/pmic_link_sva.sv ====
// Wire-level checks on the serial link between host and device
`timescale 1ns/1ps
module pmic_link_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Link lines
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe
);
  import pmic_link_pkg::*;
  logic       p_scl, p_sda, first, hit, rd;
  logic [3:0] bits;
  logic [7:0] shreg;
  logic [5:0] run;
  logic       start, stop, rise, fall, ack, armed;
  // Line events seen from one cycle to the next
  assign start = scl & p_scl & p_sda & ~sda;
  assign stop  = scl & p_scl & ~p_sda & sda;
  assign rise  = scl & ~p_scl;
  assign fall  = ~scl & p_scl;
  assign ack   = rise & (bits == 4'h8);
  // Byte tracker; run saturates so long idle spans stay legal.
  // A pulse counts as a bit only when it falls with no start or stop
  // in between, so the pulse that frames a start or stop is not a bit.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      p_scl <= 1'h1;
      p_sda <= 1'h1;
      first <= 1'h0;
      hit   <= 1'h0;
      rd    <= 1'h0;
      bits  <= 4'h0;
      shreg <= 8'h00;
      run   <= 6'h3F;
      armed <= 1'h0;
    end else begin
      p_scl <= scl;
      p_sda <= sda;
      run   <= (scl != p_scl) ? 6'h01 : (run == 6'h3F) ? run : run + 6'h01;
      if (start) begin
        bits  <= 4'h0;
        first <= 1'h1;
        armed <= 1'h0;
      end else if (stop) begin
        bits  <= 4'h0;
        first <= 1'h0;
        hit   <= 1'h0;
        armed <= 1'h0;
      end else if (rise) begin
        armed <= 1'h1;
        if (bits != 4'h8) begin
          shreg <= {shreg[6:0], sda};
        end
      end else if (fall && armed) begin
        armed <= 1'h0;
        if (bits == 4'h8) begin
          bits  <= 4'h0;
          first <= 1'h0;
          if (first) begin
            hit <= (shreg[7:1] == SLAVE_ADDR);
            rd  <= shreg[0];
          end
        end else begin
          bits  <= bits + 4'h1;
        end
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_edges_framed: assert property ((start || stop) |-> bits == 4'h0)
    else $error("start or stop inside a byte");
  a_dev_moves_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved data while clock high");
  a_link_rate: assert property (scl != p_scl |-> run >= 6'h10)
    else $error("clock phase shorter than a quarter bit");
  a_addr_ack: assert property (ack && first |->
    dev_sda_oe == (shreg[7:1] == SLAVE_ADDR))
    else $error("address acknowledge wrong");
  a_write_ack: assert property (
    ack && !first && hit && !rd |-> dev_sda_oe)
    else $error("written byte not acknowledged");
  a_ack_hold: assert property (ack && dev_sda_oe |=> dev_sda_oe [*8])
    else $error("acknowledge not held through clock high");
  a_read_release: assert property (
    ack && !first && hit && rd |-> !dev_sda_oe)
    else $error("device held data at read acknowledge");
  a_idle_quiet: assert property (!hit && !first |-> !dev_sda_oe)
    else $error("device drove data while not addressed");
  c_write: cover property (ack && !first && hit && !rd);
  c_stop: cover property (stop && hit);
  c_read: cover property (ack && !first && hit && rd);
  c_restart: cover property (start && hit);
endmodule : pmic_link_sva

// ==== tb/tb_pmic_serial_status_enable_regs.sv ====
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps
module tb_pmic_serial_status_enable_regs;
  import pmic_link_pkg::*;
  localparam logic [7:0] VER = 8'h3C;  // Arbitrary code
  localparam logic [7:0] RA [5] = '{REG_VERSION, REG_MASK, REG_ENABLE,
                                    8'h04, 8'h7F};
  localparam logic [7:0] RE [5] = '{VER, MASK_RESET, ENABLE_RESET,
                                    READ_UNMAPPED, READ_UNMAPPED};
  localparam logic [7:0] EV [3] = '{8'hD5, 8'h2A, 8'h00};
  logic        ref_clk, arst_n, lockout, pf, lb, ramp, device_on, int_n_oe;
  logic        int_n_pin;
  logic [4:0]  rail_low, supply_on;
  logic [3:0]  pins, wb_sel;
  logic        wb_we, wb_stb, wb_cyc, wb_ack;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat_w, wb_dat_r, hq;
  int          num_errors, checks_done, cycles;

  pmic_link_if link_if ();
  pmic_serial_regs #(.VERSION_CODE(VER)) i_pmic_serial_regs (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'h1), .link(link_if),
    .supply_undervolt_lockout(lockout), .power_fail_sense(pf),
    .low_battery_sense(lb), .rail_below_target(rail_low),
    .core_voltage_ramp(ramp), .buck1_enable_pin(pins[3]),
    .buck2_enable_pin(pins[2]), .buck3_enable_pin(pins[1]),
    .linear_reg_enable_pin(pins[0]), .supply_on(supply_on),
    .device_on(device_on), .int_n_o(int_n_pin), .int_n_oe(int_n_oe));
  pmic_link_host i_pmic_link_host (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'h1),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat_w), .wb_sel_i(wb_sel),
    .wb_we_i(wb_we), .wb_stb_i(wb_stb), .wb_cyc_i(wb_cyc),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .link(link_if));
  pmic_link_sva i_pmic_link_sva (
    .ref_clk(ref_clk), .arst_n(arst_n), .scl(link_if.scl),
    .sda(link_if.sda), .dev_sda_oe(link_if.dev_sda_oe));

  // Free-running 25 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Hang guard: a stuck handshake counts as a mismatch
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic [31:0] d,
                    input logic we, input logic [3:0] sel,
                    output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_sel <= sel;
    wb_adr <= a;
    wb_dat_w <= d;
    do @(posedge ref_clk); while (wb_ack !== 1'h1);
    q = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
  endtask : wb

  // Start one link access, then poll busy until the stop is sent
  task automatic xfer(input logic r, input logic [7:0] ra,
                      input logic [7:0] d, output logic [7:0] q);
    logic [31:0] s;
    wb(HOST_CTRL_ADDR, {15'h0000, r, ra, d}, 1'h1, 4'hF, s);
    s = 32'h0000_0001;
    for (int i = 0; i < 3000 && s[0] === 1'h1; i++)
      wb(HOST_STAT_ADDR, 32'h0000_0000, 1'h0, 4'hF, s);
    // A poll limit that runs out leaves busy set and counts here
    check({31'h0, s[0]}, 32'h0000_0000);
    check({31'h0, s[1]}, 32'h0000_0000);
    q = s[15:8];
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'h0, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'h1, a, 8'h00, q);
    check({24'h0, q}, {24'h0, e});
  endtask : rd_chk

  // Inputs pass a two-stage synchroniser before they act
  task automatic settle();
    repeat (6) @(posedge ref_clk);
  endtask : settle

  initial begin
    arst_n = 1'h0; lockout = 1'h0; pf = 1'h0; lb = 1'h0; ramp = 1'h0;
    rail_low = 5'h00; pins = 4'hF; wb_sel = 4'hF; wb_we = 1'h0;
    wb_stb = 1'h0; wb_cyc = 1'h0; wb_adr = 8'h00; wb_dat_w = 32'h0;
    num_errors = 0; checks_done = 0; cycles = 0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 5; i++) rd_chk(RA[i], RE[i]);
    wb(8'h08, 32'hFFFF_FFFF, 1'h1, 4'hF, hq);
    wb(8'h08, 32'h0000_0000, 1'h0, 4'hF, hq);
    check(hq, 32'h0000_0000);
    // A command without its start lane must not begin a transfer
    wb(HOST_CTRL_ADDR, 32'h0001_0000, 1'h1, 4'h3, hq);
    wb(HOST_STAT_ADDR, 32'h0000_0000, 1'h0, 4'hF, hq);
    check({31'h0, hq[0]}, 32'h0000_0000);
    // mask writes, reserved bit stays zero
    wr(REG_MASK, 8'hFF);
    rd_chk(REG_MASK, MASK_WRITABLE);
    wr(REG_MASK, 8'h00);
    rd_chk(REG_MASK, 8'h00);
    foreach (EV[i]) begin
      wr(REG_ENABLE, EV[i]);
      rd_chk(REG_ENABLE, EV[i] | ~ENABLE_WRITABLE);
      check({27'h0, supply_on}, {27'h0, EV[i][5:1]});
    end
    check({31'h0, int_n_oe}, 32'h1);
    // low pins push their bits back to one
    @(posedge ref_clk);
    pins <= 4'hA;
    settle();
    check({27'h0, supply_on}, 32'h0);
    @(posedge ref_clk);
    pins <= 4'hF;
    settle();
    check({27'h0, supply_on}, 32'h0B);
    rd_chk(REG_ENABLE, 8'hD7);
    // status flags, ramp and disabled rails
    wr(REG_ENABLE, 8'hFF);
    @(posedge ref_clk);
    pf <= 1'h1;
    rail_low <= 5'h15;
    settle();
    rd_chk(REG_STATUS, 8'hAA);
    ramp <= 1'h1;
    settle();
    rd_chk(REG_STATUS, 8'hA2);
    pf <= 1'h0;
    lb <= 1'h1;
    ramp <= 1'h0;
    rail_low <= 5'h0A;
    settle();
    rd_chk(REG_STATUS, 8'h54);
    wr(REG_ENABLE, 8'h00);
    rd_chk(REG_STATUS, 8'h40);
    @(posedge ref_clk);
    lb <= 1'h0;
    rail_low <= 5'h00;
    wr(REG_ENABLE, 8'hFF);
    check({31'h0, int_n_oe}, 32'h0);
    check({31'h0, int_n_pin}, 32'h0);
    rail_low <= 5'h08;
    settle();
    check({31'h0, int_n_oe}, 32'h1);
    rd_chk(REG_STATUS, 8'h10);
    check({31'h0, int_n_oe}, 32'h0);
    rail_low <= 5'h00;
    wr(REG_MASK, 8'h10);
    rail_low <= 5'h08;
    settle();
    check({31'h0, int_n_oe}, 32'h0);
    rail_low <= 5'h04;
    settle();
    check({31'h0, int_n_oe}, 32'h1);
    // lockout turns all off and reloads defaults
    wr(REG_ENABLE, 8'h00);
    @(posedge ref_clk);
    lockout <= 1'h1;
    settle();
    check({31'h0, device_on}, 32'h0);
    lockout <= 1'h0;
    settle();
    check({31'h0, device_on}, 32'h1);
    rd_chk(REG_MASK, MASK_RESET);
    rd_chk(REG_ENABLE, ENABLE_RESET);
    check({27'h0, supply_on}, 32'h1F);
    tally_and_finish();
  end
endmodule : tb_pmic_serial_status_enable_regs
